// File: dv/bcc_host_model.sv
// host bus master model that reaches the clock registers
`timescale 1ns/1ps
`default_nettype none
module bcc_host_model
  import bcc_pkg::*;
(
  input  wire logic        core_clk,   // system clock
  output var  logic [15:0] busAddr,    // address to block
  output var  logic [7:0]  busWrData,  // write data to block
  output var  logic        busRd,      // read strobe
  output var  logic        busWr,      // write strobe
  input  wire logic [7:0]  busRdData,  // read data from block
  input  wire logic        busAck      // access taken
);
  initial begin
    busAddr   = 16'h0000;
    busWrData = 8'h00;
    busRd     = 1'b0;
    busWr     = 1'b0;
  end

  // ----------------------------------------
  // single accesses of one strobe cycle each, then a lock poll that holds the read strobe
  // ----------------------------------------
  // digit writes are issued whether or not counting is held
  task automatic wr(input logic [3:0] off, input logic [7:0] d);
    @(posedge core_clk);
    #1;
    busAddr   = RTC_BASE | {12'h000, off};
    busWrData = d;
    busWr     = 1'b1;
    @(posedge core_clk);
    #1;
    busWr     = 1'b0;
    busWrData = ~d;
  endtask

  task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ack);
    @(posedge core_clk);
    #1;
    busAddr = a;
    busRd   = 1'b1;
    @(posedge core_clk);
    #1;
    busRd = 1'b0;
    d     = busRdData;
    ack   = busAck;
  endtask

  // back to back reads of control d, counting cycles that show the lock flag
  task automatic poll_lock(input int n, output int seen);
    seen = 0;
    @(posedge core_clk);
    #1;
    busAddr = RTC_BASE | {12'h000, OFF_CTL_D};
    busRd   = 1'b1;
    repeat (n) begin
      @(posedge core_clk);
      #1;
      if (busAck === 1'b1 && busRdData[D_LOCK] === 1'b1) seen++;
    end
    busRd = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: dv/tb_top.sv
// self-checking testbench for the bcd calendar clock registers
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bcc_pkg::*;
;
  localparam int TICKS    = 8;
  localparam int PULSES   = 20;
  localparam int WAIT_SEC = 64 * TICKS + 88;
  localparam logic [51:0] RST_T = 52'h0000101120000;
  localparam logic [51:0] T12   = 52'h2040228515959;

  logic        core_clk;
  logic        reset_n;
  logic        clkEn;
  logic [15:0] busAddr;
  logic [7:0]  busWrData;
  logic        busRd;
  logic        busWr;
  logic [7:0]  busRdData;
  logic        busAck;
  logic        irqOut;
  logic [7:0]  v;
  logic        a;
  int          n_errors;
  int          n_compared;
  int          seen;
  int          high;
  logic [1:0]  perT [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h3, 2'h3};
  logic [3:0]  minV [6] = '{4'h8, 4'h8, 4'h8, 4'h8, 4'h8, 4'h9};
  logic [3:0]  secV [6] = '{4'h8, 4'h8, 4'h8, 4'h9, 4'h9, 4'h9};
  logic        expI [6] = '{1'b1, 1'b1, 1'b0, 1'b1, 1'b0, 1'b1};

  bcc_clock_regs #(.TICK64_CYCLES(TICKS), .PULSE_CYCLES(PULSES)) dut (
    .core_clk(core_clk), .reset_n(reset_n), .clkEn(clkEn), .busAddr(busAddr),
    .busWrData(busWrData), .busRd(busRd), .busWr(busWr), .busRdData(busRdData),
    .busAck(busAck), .irqOut(irqOut));

  bcc_host_model host (
    .core_clk(core_clk), .busAddr(busAddr), .busWrData(busWrData), .busRd(busRd),
    .busWr(busWr), .busRdData(busRdData), .busAck(busAck));

  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask

  task automatic rdc(input logic [3:0] off, input logic [7:0] exp);
    logic [7:0] d;
    logic       k;
    host.rd(RTC_BASE | {12'h000, off}, d, k);
    check($sformatf("reg %0h", off), d, exp);
    check($sformatf("ack %0h", off), {7'h0, k}, 8'h01);
  endtask

  // upper nibble set on every write, so each load also checks it is dropped
  task automatic set_all(input logic [51:0] t);
    for (int i = 0; i < 13; i++) host.wr(4'(i), {4'ha, t[i*4 +: 4]});
  endtask

  task automatic cmp_all(input logic [51:0] t);
    for (int i = 0; i < 13; i++) rdc(4'(i), {4'h0, t[i*4 +: 4]});
  endtask

  task automatic tick_case(input logic [3:0] f, input logic [3:0] d,
                           input logic [51:0] st, input logic [51:0] ex);
    host.wr(OFF_CTL_F, {4'h0, f | 4'h1});
    set_all(st);
    host.wr(OFF_CTL_D, {4'h0, d});
    host.wr(OFF_CTL_F, {4'h0, f});
    cyc(WAIT_SEC);
    cmp_all(ex);
  endtask

  initial begin
    repeat (60000) @(posedge core_clk);
    n_errors++;
    final_report();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    n_errors   = 0;
    n_compared = 0;
    clkEn      = 1'b1;
    reset_n    = 1'b0;
    repeat (20) @(posedge core_clk);
    #1;
    reset_n = 1'b1;
    cmp_all(RST_T);
    // pulse outlasts the 1/64 period here, so pending stays up after the first tick
    rdc(OFF_CTL_D, 8'h04);
    for (int i = 14; i < 16; i++) rdc(4'(i), 8'h00);
    host.rd(16'hffd0, v, a);
    check("unmapped ack", {7'h0, a}, 8'h00);
    check("unmapped data", v, 8'h00);
    host.wr(OFF_CTL_F, 8'hf1);
    rdc(OFF_CTL_F, 8'h01);
    host.wr(OFF_CTL_E, 8'hf6);
    rdc(OFF_CTL_E, 8'h06);
    set_all({13{4'hf}});
    cmp_all(52'h7ff1f3f7f7f7f);
    set_all(52'h0000101121045);
    host.wr(OFF_CTL_D, 8'h08);
    cmp_all(52'h0000101121100);
    rdc(OFF_CTL_D, 8'h00);
    set_all(52'h0000101121129);
    host.wr(OFF_CTL_D, 8'h08);
    cmp_all(52'h0000101121100);
    tick_case(4'h4, 4'h0, 52'h6991231235959, 52'h0000101000000);
    tick_case(4'h0, 4'h0, T12, 52'h3040229120000);
    tick_case(4'h2, 4'h0, T12, T12);
    tick_case(4'h0, 4'h1, T12, T12);
    host.wr(OFF_CTL_D, 8'h00);
    host.wr(OFF_CTL_F, 8'h01);
    set_all(RST_T);
    host.wr(OFF_CTL_F, 8'h08);
    cyc(100);
    host.rd(RTC_BASE | 16'h0001, v, a);
    check("test source", {7'h0, (v[2:0] != 3'h0)}, 8'h01);
    // clock enable low: no second may pass although a full second of cycles elapses
    host.wr(OFF_CTL_F, 8'h01);
    host.wr(OFF_SEC_U, 8'h00);
    host.wr(OFF_CTL_F, 8'h00);
    clkEn = 1'b0;
    cyc(WAIT_SEC);
    clkEn = 1'b1;
    rdc(OFF_SEC_U, 8'h00);
    host.poll_lock(WAIT_SEC, seen);
    check("lock seen", {7'h0, (seen inside {[1:2]})}, 8'h01);
    for (int i = 0; i < 6; i++) begin
      host.wr(OFF_CTL_F, 8'h01);
      host.wr(OFF_MIN_T, 8'h05);
      host.wr(OFF_MIN_U, {4'h0, minV[i]});
      host.wr(OFF_SEC_T, 8'h05);
      host.wr(OFF_SEC_U, {4'h0, secV[i]});
      host.wr(OFF_CTL_D, 8'h00);
      host.wr(OFF_CTL_E, {4'h0, perT[i], 2'b10});
      host.wr(OFF_CTL_F, 8'h00);
      cyc(WAIT_SEC);
      check("irq period", {7'h0, irqOut}, {7'h0, expI[i]});
    end
    cyc(WAIT_SEC);
    check("irq latched", {7'h0, irqOut}, 8'h01);
    rdc(OFF_CTL_D, 8'h04);
    host.wr(OFF_CTL_D, 8'h00);
    cyc(3);
    check("irq cleared", {7'h0, irqOut}, 8'h00);
    host.wr(OFF_CTL_E, 8'h07);
    host.wr(OFF_CTL_F, 8'h01);
    host.wr(OFF_CTL_F, 8'h00);
    cyc(WAIT_SEC);
    check("irq masked", {7'h0, irqOut}, 8'h00);
    rdc(OFF_CTL_D, 8'h04);
    host.wr(OFF_CTL_E, 8'h06);
    cyc(3);
    check("irq unmasked", {7'h0, irqOut}, 8'h01);
    host.wr(OFF_CTL_F, 8'h01);
    host.wr(OFF_CTL_D, 8'h00);
    host.wr(OFF_CTL_E, 8'h04);
    host.wr(OFF_CTL_F, 8'h00);
    for (int k = 0; k < WAIT_SEC && irqOut !== 1'b1; k++) cyc(1);
    high = 0;
    while (irqOut === 1'b1 && high < 100) begin
      high++;
      cyc(1);
    end
    check("pulse length", {7'h0, (high inside {[PULSES-1:PULSES+1]})}, 8'h01);
    final_report();
  end
endmodule
`default_nettype wire

// File: rtl/bcc_clock_regs.sv
// bcd calendar clock with sixteen 4-bit host registers
`timescale 1ns/1ps
`default_nettype none
module bcc_clock_regs
  import bcc_pkg::*;
#(
  parameter int TICK64_CYCLES = TICK64_CYC,
  parameter int PULSE_CYCLES  = PULSE_CYC
) (
  input  wire logic        core_clk,   // system clock
  input  wire logic        reset_n,    // async reset, active low
  input  wire logic        clkEn,      // freezes all state when low
  input  wire logic [15:0] busAddr,    // host data address
  input  wire logic [7:0]  busWrData,  // host write data
  input  wire logic        busRd,      // read strobe, one cycle
  input  wire logic        busWr,      // write strobe, one cycle
  output var  logic [7:0]  busRdData,  // read data, registered
  output var  logic        busAck,     // read or write taken, registered
  output var  logic        irqOut      // interrupt, active high
);

  // ------------------------------------------------------------
  // functions
  // ------------------------------------------------------------
  function automatic logic [5:0] monthLen(input bcc_time_s t);
    logic leap;
    logic [4:0] m;
    leap = t.yrT[0] ? (t.yrU == 4'h2 || t.yrU == 4'h6)
                    : (t.yrU == 4'h0 || t.yrU == 4'h4 || t.yrU == 4'h8);
    m = {t.monT, t.monU};
    if (m == 5'h02) begin
      monthLen = leap ? 6'h29 : 6'h28;
    end else if (m == 5'h04 || m == 5'h06 || m == 5'h09 || m == 5'h11) begin
      monthLen = 6'h30;
    end else begin
      monthLen = 6'h31;
    end
  endfunction

  // advance by one second, or by one minute with seconds cleared
  function automatic bcc_time_s nextTime(input bcc_time_s t, input logic h24,
                                         input logic fromMin);
    bcc_time_s n;
    logic incMin;
    logic incHr;
    logic incDay;
    logic incMon;
    n = t;
    incDay = 1'b0;
    incMin = fromMin || (t.secU == 4'h9 && t.secT == 3'h5);
    if (fromMin) begin
      n.secU = 4'h0;
      n.secT = 3'h0;
    end else if (t.secU != 4'h9) begin
      n.secU = t.secU + 4'h1;
    end else begin
      n.secU = 4'h0;
      n.secT = (t.secT == 3'h5) ? 3'h0 : t.secT + 3'h1;
    end
    incHr = incMin && t.minU == 4'h9 && t.minT == 3'h5;
    if (incMin) begin
      if (t.minU != 4'h9) begin
        n.minU = t.minU + 4'h1;
      end else begin
        n.minU = 4'h0;
        n.minT = (t.minT == 3'h5) ? 3'h0 : t.minT + 3'h1;
      end
    end
    if (incHr) begin
      if (h24 && t.hrT == 2'h2 && t.hrU == 4'h3) begin // [R15]
        n.hrT = 2'h0;
        n.hrU = 4'h0;
        incDay = 1'b1;
      end else if (!h24 && t.hrT == 2'h1 && t.hrU == 4'h2) begin
        n.hrT = 2'h0;
        n.hrU = 4'h1;
      end else begin
        // 11 to 12 flips the half of day; pm to am starts a new day
        if (!h24 && t.hrT == 2'h1 && t.hrU == 4'h1) begin
          n.pm = ~t.pm;
          incDay = t.pm;
        end
        if (t.hrU != 4'h9) begin
          n.hrU = t.hrU + 4'h1;
        end else begin
          n.hrU = 4'h0;
          n.hrT = t.hrT + 2'h1;
        end
      end
    end
    incMon = incDay && {t.dayT, t.dayU} == monthLen(t);
    if (incDay) begin
      n.wday = (t.wday == 3'h6) ? 3'h0 : t.wday + 3'h1;
      if (incMon) begin
        n.dayT = 2'h0;
        n.dayU = 4'h1;
      end else if (t.dayU != 4'h9) begin
        n.dayU = t.dayU + 4'h1;
      end else begin
        n.dayU = 4'h0;
        n.dayT = t.dayT + 2'h1;
      end
    end
    if (incMon) begin
      if (t.monT && t.monU == 4'h2) begin
        n.monT = 1'b0;
        n.monU = 4'h1;
        if (t.yrU != 4'h9) begin
          n.yrU = t.yrU + 4'h1;
        end else begin
          n.yrU = 4'h0;
          n.yrT = (t.yrT == 4'h9) ? 4'h0 : t.yrT + 4'h1;
        end
      end else if (t.monU == 4'h9) begin
        n.monT = 1'b1;
        n.monU = 4'h0;
      end else begin
        n.monU = t.monU + 4'h1;
      end
    end
    nextTime = n;
  endfunction

  // host write of one digit, unused bits dropped
  function automatic bcc_time_s writeDigit(input bcc_time_s t, input logic [3:0] idx,
                                           input logic [3:0] d);
    bcc_time_s n;
    n = t;
    case (idx)
      OFF_SEC_U: n.secU = d;
      OFF_SEC_T: n.secT = d[2:0];
      OFF_MIN_U: n.minU = d;
      OFF_MIN_T: n.minT = d[2:0];
      OFF_HR_U:  n.hrU = d;
      OFF_HR_T: begin
        n.hrT = d[1:0];
        n.pm  = d[2];
      end
      OFF_DAY_U: n.dayU = d;
      OFF_DAY_T: n.dayT = d[1:0];
      OFF_MON_U: n.monU = d;
      OFF_MON_T: n.monT = d[0];
      OFF_YR_U:  n.yrU = d;
      OFF_YR_T:  n.yrT = d;
      OFF_WDAY:  n.wday = d[2:0];
      default:   n = t;
    endcase
    writeDigit = n;
  endfunction

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  bcc_time_s   time_q;
  bcc_time_s   time_d;
  logic [17:0] presc_q;
  logic [5:0]  subSec_q;
  logic        pendSec_q;
  logic        adv_q;
  logic        pend_q;
  logic        pend_d;
  logic [16:0] pulseCnt_q;
  logic [3:0]  ctlE_q;
  logic [3:0]  ctlF_q;
  logic        store_q;
  logic [3:0]  rdVal;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  wire       hit      = busAddr[15:4] == RTC_BASE[15:4]; // [R18]
  wire [3:0] idx      = busAddr[3:0];
  wire [3:0] wd       = busWrData[3:0]; // [R19]
  wire       wrHit    = busWr && hit;
  wire       lock     = adv_q;
  wire       wrDigit  = wrHit && !lock && idx <= OFF_WDAY; // [R8]
  wire       wrD      = wrHit && idx == OFF_CTL_D;
  wire       roundReq = wrD && wd[D_ROUND];
  wire       h24      = ctlF_q[F_H24];
  wire       stop     = ctlF_q[F_STOP];
  wire       intMode  = ctlE_q[E_MODE];
  wire       intMask  = ctlE_q[E_MASK];

  // ------------------------------------------------------------
  // divider chain
  // ------------------------------------------------------------
  wire tick64   = presc_q == 18'(TICK64_CYCLES - 1);
  wire secRaw   = tick64 && subSec_q == SUBSEC_LAST;
  wire secSrc   = ctlF_q[F_TEST] ? tick64 : secRaw; // [R14]
  wire secEvt   = secSrc || pendSec_q;
  wire advance  = secEvt && !stop && !store_q; // [R16] [R9]
  wire minWrap  = time_q.secU == 4'h9 && time_q.secT == 3'h5;
  wire hrWrap   = minWrap && time_q.minU == 4'h9 && time_q.minT == 3'h5;

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      presc_q  <= 18'h0;
      subSec_q <= 6'h0;
    end else if (clkEn) begin
      if (ctlF_q[F_RST] || tick64) begin // [R17]
        presc_q <= 18'h0;
      end else begin
        presc_q <= presc_q + 18'h1;
      end
      if (ctlF_q[F_RST]) begin // [R17]
        subSec_q <= 6'h0;
      end else if (tick64) begin
        subSec_q <= subSec_q + 6'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // time and date
  // ------------------------------------------------------------
  bcc_time_s roundT;
  bcc_time_s baseT;
  assign roundT = (time_q.secT >= 3'h3) ? nextTime(time_q, h24, 1'b1) // [R6]
                : writeDigit(writeDigit(time_q, OFF_SEC_U, 4'h0), OFF_SEC_T, 4'h0);
  assign baseT  = roundReq ? roundT : adv_q ? nextTime(time_q, h24, 1'b0) : time_q; // [R20]
  assign time_d = wrDigit ? writeDigit(baseT, idx, wd) : baseT; // [R2]

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      time_q    <= TIME_RST;
      adv_q     <= 1'b0;
      pendSec_q <= 1'b0;
    end else if (clkEn) begin
      time_q    <= time_d;
      adv_q     <= advance;
      // a second seen while held and not stopped is kept for later; one seen while stopped is dropped
      pendSec_q <= secEvt && store_q && !stop;
    end
  end

  // ------------------------------------------------------------
  // interrupt
  // ------------------------------------------------------------
  wire periodEvt = (ctlE_q[E_PER+:2] == 2'h0) ? tick64 // [R10]
                 : (ctlE_q[E_PER+:2] == 2'h1) ? adv_q
                 : (ctlE_q[E_PER+:2] == 2'h2) ? adv_q && minWrap
                 : adv_q && hrWrap;
  wire swClear   = wrD && !wd[D_PEND] && intMode; // [R7]
  wire pulseEnd  = !intMode && pulseCnt_q == 17'h1; // [R12]

  // a new period event wins over a clear in the same cycle
  assign pend_d = periodEvt ? 1'b1 : (swClear || pulseEnd) ? 1'b0 : pend_q; // [R11]

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      pend_q     <= 1'b0;
      pulseCnt_q <= 17'h0;
      irqOut     <= 1'b0;
    end else if (clkEn) begin
      pend_q <= pend_d;
      if (periodEvt) begin
        pulseCnt_q <= 17'(PULSE_CYCLES);
      end else if (pulseCnt_q != 17'h0) begin
        pulseCnt_q <= pulseCnt_q - 17'h1;
      end
      irqOut <= pend_q && !intMask; // [R13]
    end
  end

  // ------------------------------------------------------------
  // control registers and host read
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      ctlE_q  <= CTL_RST;
      ctlF_q  <= CTL_RST;
      store_q <= 1'b0;
    end else if (clkEn) begin
      if (wrD) begin
        store_q <= wd[D_STORE];
      end
      if (wrHit && idx == OFF_CTL_E) begin
        ctlE_q <= wd;
      end
      if (wrHit && idx == OFF_CTL_F) begin
        ctlF_q <= wd;
      end
    end
  end

  always_comb begin
    rdVal = 4'h0;
    case (idx)
      OFF_SEC_U: rdVal = time_q.secU;
      OFF_SEC_T: rdVal = {1'b0, time_q.secT};
      OFF_MIN_U: rdVal = time_q.minU;
      OFF_MIN_T: rdVal = {1'b0, time_q.minT};
      OFF_HR_U:  rdVal = time_q.hrU;
      OFF_HR_T:  rdVal = {1'b0, time_q.pm, time_q.hrT}; // [R3]
      OFF_DAY_U: rdVal = time_q.dayU;
      OFF_DAY_T: rdVal = {2'h0, time_q.dayT}; // [R4]
      OFF_MON_U: rdVal = time_q.monU;
      OFF_MON_T: rdVal = {3'h0, time_q.monT};
      OFF_YR_U:  rdVal = time_q.yrU;
      OFF_YR_T:  rdVal = time_q.yrT;
      OFF_WDAY:  rdVal = {1'b0, time_q.wday}; // [R5]
      OFF_CTL_D: rdVal = {1'b0, pend_q, lock, store_q}; // [R7] [R8]
      OFF_CTL_E: rdVal = ctlE_q;
      OFF_CTL_F: rdVal = ctlF_q;
      default:   rdVal = 4'h0;
    endcase
  end

  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      busRdData <= 8'h00;
      busAck    <= 1'b0;
    end else if (clkEn) begin
      busAck    <= hit && (busRd || busWr); // [R1]
      busRdData <= (hit && busRd) ? {4'h0, rdVal} : 8'h00; // [R19]
    end
  end

  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);

  sequence s_rdReq;
    clkEn && busRd && hit;
  endsequence
  sequence s_roundHi;
    clkEn && roundReq && time_q.secT >= 3'h3 && !(wrDigit && idx == OFF_MIN_U);
  endsequence

  property p_rdAck;
    s_rdReq |=> busAck && busRdData[7:4] == 4'h0;
  endproperty
  a_rdAck: assert property (p_rdAck) else $error("read not acknowledged"); // [R1]

  property p_rdUpper;
    busAck |-> busRdData[7:4] == 4'h0;
  endproperty
  a_rdUpper: assert property (p_rdUpper) else $error("upper read bits set"); // [R19]

  property p_round;
    s_roundHi |=> time_q.secU == 4'h0 && time_q.secT == 3'h0 && time_q.minU != $past(time_q.minU);
  endproperty
  a_round: assert property (p_round) else $error("rounding failed"); // [R6]

  property p_mask;
    clkEn && intMask |=> !irqOut;
  endproperty
  a_mask: assert property (p_mask) else $error("masked interrupt seen"); // [R13]

  property p_follow;
    clkEn && !intMask && pend_q |=> irqOut;
  endproperty
  a_follow: assert property (p_follow) else $error("interrupt not following"); // [R13]

  property p_latch;
    clkEn && intMode && pend_q && !swClear |=> pend_q;
  endproperty
  a_latch: assert property (p_latch) else $error("latched interrupt lost"); // [R11]

  property p_pulseEnd;
    clkEn && !intMode && pulseCnt_q == 17'h1 && !periodEvt |=> !pend_q;
  endproperty
  a_pulseEnd: assert property (p_pulseEnd) else $error("pulse not ended"); // [R12]

  property p_stop;
    clkEn && stop |=> !adv_q;
  endproperty
  a_stop: assert property (p_stop) else $error("counting while stopped"); // [R16]

  property p_cntRst;
    clkEn && ctlF_q[F_RST] |=> presc_q == 18'h0 && subSec_q == 6'h0;
  endproperty
  a_cntRst: assert property (p_cntRst) else $error("divider not reset"); // [R17]

  property p_hold;
    clkEn && store_q && !adv_q && !wrDigit && !roundReq |=> time_q == $past(time_q);
  endproperty
  a_hold: assert property (p_hold) else $error("time moved while held"); // [R9]

endmodule
`default_nettype wire

// File: rtl/bcc_pkg.sv
// constants and types for the bcd calendar clock register block
// Overview of operation
// R1: sixteen consecutive locations, thirteen data and three control, all read and write
// R2: data reads return current digit; writes load it to set time and date
// R3: seconds/minutes units 4 bits, tens 3; hours units 4, tens 2, bit2 pm
// R4: day, month, year units 4 bits; day tens 2, month tens 1, year tens 4
// R5: weekday 3 bits, 0 Sunday through 6 Saturday
// R6: setting round bit clears seconds; at 30 or more also increments minutes
// R7: pending flag reads interrupt state; writing 0 in latched mode clears it
// R8: lock flag reads 1 while register access is refused, 0 otherwise
// R9: while store flag is 1, written time and date are held still
// R10: period field selects interrupt interval: 1/64 s, 1 s, 1 min, 1 h
// R11: latched mode: interrupt asserts on period and stays until software clears
// R12: pulsed mode: interrupt asserts on period and drops alone after 7.8 ms
// R13: mask bit 1 keeps interrupt output inactive; 0 lets it follow status
// R14: test bit takes count from fast main counter, else from slow divider
// R15: hour-format bit 1 counts 0 to 23; 0 counts 1 to 12 with pm
// R16: stop bit halts time counting until written back to 0
// R17: writing 1 to counter-reset bit clears all internal divider counters
// R18: registers decode at ffc0 to ffcf, seconds units first, control f last
// R19: upper four bits and unused digit bits read zero and ignore writes
// R20: digits count as decimal with carries, month lengths and weekday advance
package bcc_pkg;

  // ------------------------------------------------------------
  // address map
  // ------------------------------------------------------------
  localparam logic [15:0] RTC_BASE    = 16'hffc0;
  localparam logic [3:0]  OFF_SEC_U   = 4'h0;
  localparam logic [3:0]  OFF_SEC_T   = 4'h1;
  localparam logic [3:0]  OFF_MIN_U   = 4'h2;
  localparam logic [3:0]  OFF_MIN_T   = 4'h3;
  localparam logic [3:0]  OFF_HR_U    = 4'h4;
  localparam logic [3:0]  OFF_HR_T    = 4'h5;
  localparam logic [3:0]  OFF_DAY_U   = 4'h6;
  localparam logic [3:0]  OFF_DAY_T   = 4'h7;
  localparam logic [3:0]  OFF_MON_U   = 4'h8;
  localparam logic [3:0]  OFF_MON_T   = 4'h9;
  localparam logic [3:0]  OFF_YR_U    = 4'ha;
  localparam logic [3:0]  OFF_YR_T    = 4'hb;
  localparam logic [3:0]  OFF_WDAY    = 4'hc;
  localparam logic [3:0]  OFF_CTL_D   = 4'hd;
  localparam logic [3:0]  OFF_CTL_E   = 4'he;
  localparam logic [3:0]  OFF_CTL_F   = 4'hf;

  // ------------------------------------------------------------
  // control bit positions
  // ------------------------------------------------------------
  localparam int D_ROUND = 3;
  localparam int D_PEND  = 2;
  localparam int D_LOCK  = 1;
  localparam int D_STORE = 0;
  localparam int E_PER   = 2;
  localparam int E_MODE  = 1;
  localparam int E_MASK  = 0;
  localparam int F_TEST  = 3;
  localparam int F_H24   = 2;
  localparam int F_STOP  = 1;
  localparam int F_RST   = 0;

  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 100;
  localparam int TICK64_NS     = 15625000;
  localparam int PULSE_NS      = 7800000;
  localparam int TICK64_CYC    = TICK64_NS / CLK_PERIOD_NS;
  localparam int PULSE_CYC     = PULSE_NS / CLK_PERIOD_NS;
  localparam logic [5:0] SUBSEC_LAST = 6'h3f;

  // ------------------------------------------------------------
  // time and date digits
  // ------------------------------------------------------------
  typedef struct packed {
    logic [3:0] secU;
    logic [2:0] secT;
    logic [3:0] minU;
    logic [2:0] minT;
    logic [3:0] hrU;
    logic [1:0] hrT;
    logic       pm;
    logic [3:0] dayU;
    logic [1:0] dayT;
    logic [3:0] monU;
    logic       monT;
    logic [3:0] yrU;
    logic [3:0] yrT;
    logic [2:0] wday;
  } bcc_time_s;

  // reset: 12 am, first of january, year 00, sunday
  localparam bcc_time_s TIME_RST = '{secU: 4'h0, secT: 3'h0, minU: 4'h0, minT: 3'h0,
                                     hrU: 4'h2, hrT: 2'h1, pm: 1'b0, dayU: 4'h1,
                                     dayT: 2'h0, monU: 4'h1, monT: 1'b0, yrU: 4'h0,
                                     yrT: 4'h0, wday: 3'h0};
  localparam logic [3:0] CTL_RST = 4'h0;

endpackage
